// ==== include/dct_pkg.sv ====
// Constants, field layout and types for the DAC channel trim register bank
package dct_pkg;
  localparam int WORD_BITS = 24;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 16;
  localparam int RANGE_W = 2;
  localparam int GAIN_W = 6;
  localparam int OFFS_W = 8;
  localparam int SEL_W = 3;
  localparam int ADDR_W = 3;
  localparam int SEL_MSB = 23;
  localparam int SEL_LSB = 21;
  localparam int ADDR_MSB = 20;
  localparam int ADDR_LSB = 18;
  localparam logic [SEL_W-1:0] SEL_FUNCTION = 3'h0;
  localparam logic [SEL_W-1:0] SEL_OUTPUT_CODE = 3'h2;
  localparam logic [SEL_W-1:0] SEL_RANGE = 3'h3;
  localparam logic [SEL_W-1:0] SEL_GAIN_TRIM = 3'h4;
  localparam logic [SEL_W-1:0] SEL_OFFSET_TRIM = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_ALL = 3'h4;
  localparam logic [ADDR_W-1:0] FUNC_NOP = 3'h0;
  localparam logic [ADDR_W-1:0] FUNC_CONFIG = 3'h1;
  localparam logic [ADDR_W-1:0] FUNC_CLEAR = 3'h4;
  localparam logic [ADDR_W-1:0] FUNC_LOAD = 3'h5;
  localparam int CFG_GND_ADJ = 5;
  localparam int CFG_P1_DIR = 4;
  localparam int CFG_P1_VAL = 3;
  localparam int CFG_P0_DIR = 2;
  localparam int CFG_P0_VAL = 1;
  localparam int CFG_READBACK_OFF = 0;
  localparam logic [DATA_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [RANGE_W-1:0] RANGE_RESET = 2'h0;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 6'h00;
  localparam logic [OFFS_W-1:0] OFFS_RESET = 8'h00;
  localparam logic [4:0] BITCNT_ZERO = 5'h00;
  localparam logic [4:0] BITCNT_LAST = 5'h17;
  typedef enum logic [1:0]
  {
    DCT_CLAMPED = 2'b00,
    DCT_WAIT_CODE = 2'b01,
    DCT_DRIVING = 2'b10
  } dct_clamp_t;
endpackage

// ==== design/dct_sync2.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dct_sync2
  import dct_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Asynchronous input and synchronised output
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // A zero-width synchroniser has nothing to carry
  if (WIDTH < 1)
  begin
    $error("dct_sync2 needs at least one bit");
  end

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stage1_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule

// ==== design/dct_serial_rx.sv ====
// Serial word receiver: shifts 24 bits on falling link clock edges while frame is low
`timescale 1ns/1ps
module dct_serial_rx
  import dct_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Synchronised link signals
  input wire logic link_clk_s,
  input wire logic link_frame_n_s,
  input wire logic link_din_s,
  // Received word
  output logic [WORD_BITS-1:0] word,
  output logic word_valid
);
  logic link_clk_d_reg;
  logic [WORD_BITS-1:0] shift_reg;
  logic [4:0] count_reg;
  logic fall;

  assign fall = link_clk_d_reg & ~link_clk_s;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      link_clk_d_reg <= 1'b0;
    else
      link_clk_d_reg <= link_clk_s;
  end

  // Bits taken on the falling link clock edge, MSB first
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      shift_reg <= '0;
      count_reg <= BITCNT_ZERO;
      word <= '0;
      word_valid <= 1'b0;
    end
    else
    begin
      word_valid <= 1'b0;
      if (link_frame_n_s)
        count_reg <= BITCNT_ZERO;
      else if (fall)
      begin
        shift_reg <= {shift_reg[WORD_BITS-2:0], link_din_s};
        if (count_reg == BITCNT_LAST)
        begin
          word <= {shift_reg[WORD_BITS-2:0], link_din_s};
          word_valid <= 1'b1;
          count_reg <= BITCNT_ZERO;
        end
        else
          count_reg <= count_reg + 5'h01;
      end
    end
  end
endmodule

// ==== design/dct_trim_bank.sv ====
// Quad DAC channel register bank with output clamp control and digital I/O port
//
// Functional notes
// - Select code 010 writes the addressed channel's output code register.
// - Output code is word bits 15..0, bit 15 most significant.
// - Channel address field picks which channel's register is written.
// - Select code 011 writes the addressed channel's range select register.
// - Range is bits 1..0; 00 ten volts, 01 and 10 wider ranges.
// - Select code 100 loads six-bit gain trim from bits 5..0.
// - Gain trim is twos complement, -32 to +31 steps, zero none.
// - Gain trim moves both full-scale points, half a step each.
// - Select code 101 loads eight-bit offset trim from bits 7..0.
// - Offset trim is twos complement, -16 to +15.875 LSB, zero none.
// - Each offset trim count moves the output one eighth LSB.
// - Outputs clamped until supplies good and a code write occurs.
// - On release, clamp gate opens and amplifier gate closes.
// - Low clamp request forces amplifier gate open, clamp gate closed.
// - Supply detector result is driven on a dedicated output.
// - Two-bit port, each bit independently input or output, readable.
// - Local ground compensation active only while its enable bit set.
// - Channel address 000..011 picks A..D; 100 picks all channels.
// - Direction bit set makes pin output; clear (default) makes input.
// - Value bits drive output pins, reflect input pins; ignored for inputs.
`timescale 1ns/1ps
module dct_trim_bank
  import dct_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial link from host
  input wire logic link_clk,
  input wire logic link_frame_n,
  input wire logic link_din,
  // Supply detector and clamp request
  input wire logic supply_good,
  input wire logic clamp_request_n,
  output logic supply_ok_out,
  // Output gates, high means closed (conducting)
  output logic amp_output_gate,
  output logic ground_clamp_gate,
  // Per channel register contents
  output logic [CHANNELS*DATA_W-1:0] channel_output_code,
  output logic [CHANNELS*RANGE_W-1:0] channel_range_select,
  output logic [CHANNELS*GAIN_W-1:0] channel_gain_trim,
  output logic [CHANNELS*OFFS_W-1:0] channel_offset_trim,
  // Function register controls
  output logic ground_adjust_en,
  output logic readback_disable,
  output logic output_clear,
  output logic output_load,
  // Two-bit I/O port; output enable low while driving
  input wire logic port_pin_zero_in,
  output logic port_pin_zero_out,
  output logic port_pin_zero_oe_n,
  input wire logic port_pin_one_in,
  output logic port_pin_one_out,
  output logic port_pin_one_oe_n,
  // Readable port state
  output logic [1:0] port_value
);
  // The address field decodes exactly four channels
  if (CHANNELS != NUM_CH)
  begin
    $error("dct_trim_bank serves exactly four channels");
  end

  logic link_clk_s;
  logic link_frame_n_s;
  logic link_din_s;
  logic supply_good_s;
  logic clamp_request_n_s;
  logic [1:0] port_in_s;
  logic [WORD_BITS-1:0] word;
  logic word_valid;
  logic [SEL_W-1:0] sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [1:0] port_dir_reg;
  logic [1:0] port_wval_reg;
  logic code_written_reg;
  dct_clamp_t clamp_reg;
  dct_clamp_t clamp_next;

  // Pin inputs pass two flip-flops
  dct_sync2 #(.WIDTH(7)) u_sync
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({link_clk, link_frame_n, link_din, supply_good, clamp_request_n,
               port_pin_one_in, port_pin_zero_in}),
    .sync_out({link_clk_s, link_frame_n_s, link_din_s, supply_good_s, clamp_request_n_s,
               port_in_s[1], port_in_s[0]})
  );

  // 24-bit words, bits on falling link clock
  dct_serial_rx u_rx
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .link_clk_s(link_clk_s),
    .link_frame_n_s(link_frame_n_s),
    .link_din_s(link_din_s),
    .word(word),
    .word_valid(word_valid)
  );

  assign sel = word[SEL_MSB:SEL_LSB];
  assign addr = word[ADDR_MSB:ADDR_LSB];
  assign wdata = word[DATA_W-1:0];

  // Channel hit: single channel or broadcast
  function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int ch);
    ch_hit = (a == ADDR_ALL) || (a == ch[ADDR_W-1:0]);
  endfunction

  // Function register word carrying one function code
  function automatic logic func_hit(input logic v, input logic [SEL_W-1:0] s, input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] f);
    func_hit = v && (s == SEL_FUNCTION) && (a == f);
  endfunction

  // Per channel registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        channel_output_code[c*DATA_W +: DATA_W] <= CODE_RESET;
        channel_range_select[c*RANGE_W +: RANGE_W] <= RANGE_RESET;
        channel_gain_trim[c*GAIN_W +: GAIN_W] <= GAIN_RESET;
        channel_offset_trim[c*OFFS_W +: OFFS_W] <= OFFS_RESET;
      end
    end
    else if (word_valid)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        if (ch_hit(addr, c))
        begin
          case (sel)
            SEL_OUTPUT_CODE:
              channel_output_code[c*DATA_W +: DATA_W] <= wdata;
            SEL_RANGE:
              channel_range_select[c*RANGE_W +: RANGE_W] <= wdata[RANGE_W-1:0];
            SEL_GAIN_TRIM:
              // Twos complement, applied half a step at each full-scale end downstream
              channel_gain_trim[c*GAIN_W +: GAIN_W] <= wdata[GAIN_W-1:0];
            SEL_OFFSET_TRIM:
              // Twos complement in eighth-LSB steps
              channel_offset_trim[c*OFFS_W +: OFFS_W] <= wdata[OFFS_W-1:0];
            // Refused select codes leave every register untouched
            default:
              ;
          endcase
        end
      end
    end
  end

  // Function register configuration bits
  // Readback itself lies outside this block; only its disable level is kept
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ground_adjust_en <= 1'b0;
      readback_disable <= 1'b0;
      port_dir_reg <= 2'h0;
      port_wval_reg <= 2'h0;
    end
    else if (func_hit(word_valid, sel, addr, FUNC_CONFIG))
    begin
      ground_adjust_en <= wdata[CFG_GND_ADJ];
      readback_disable <= wdata[CFG_READBACK_OFF];
      port_dir_reg <= {wdata[CFG_P1_DIR], wdata[CFG_P0_DIR]};
      // Value ignored for pins staying inputs
      if (wdata[CFG_P0_DIR])
        port_wval_reg[0] <= wdata[CFG_P0_VAL];
      if (wdata[CFG_P1_DIR])
        port_wval_reg[1] <= wdata[CFG_P1_VAL];
    end
  end

  // Clear and load strobes, one cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      output_clear <= 1'b0;
      output_load <= 1'b0;
    end
    else
    begin
      output_clear <= func_hit(word_valid, sel, addr, FUNC_CLEAR);
      output_load <= func_hit(word_valid, sel, addr, FUNC_LOAD);
    end
  end

  // I/O port pins and readable state
  // Drivers follow the registers one cycle later, so direction and value move together
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      port_pin_zero_out <= 1'b0;
      port_pin_one_out <= 1'b0;
      port_pin_zero_oe_n <= 1'b1;
      port_pin_one_oe_n <= 1'b1;
      port_value <= 2'h0;
    end
    else
    begin
      port_pin_zero_out <= port_wval_reg[0];
      port_pin_one_out <= port_wval_reg[1];
      port_pin_zero_oe_n <= ~port_dir_reg[0];
      port_pin_one_oe_n <= ~port_dir_reg[1];
      for (int b = 0; b < 2; b++)
        port_value[b] <= port_dir_reg[b] ? port_wval_reg[b] : port_in_s[b];
    end
  end

  // Supply detector result to its own pin
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      supply_ok_out <= 1'b0;
    else
      supply_ok_out <= supply_good_s;
  end

  // Code write seen since supplies became good
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      code_written_reg <= 1'b0;
    else if (!supply_good_s)
      code_written_reg <= 1'b0;
    // A refused channel address writes no register, so it cannot release the clamp
    else if (word_valid && sel == SEL_OUTPUT_CODE && addr <= ADDR_ALL)
      code_written_reg <= 1'b1;
  end

  // Clamp state machine
  // Loss of supply or a clamp request always returns to the clamped state
  always_comb
  begin
    clamp_next = clamp_reg;
    case (clamp_reg)
      DCT_CLAMPED:
        if (supply_good_s && clamp_request_n_s)
          clamp_next = DCT_WAIT_CODE;
      DCT_WAIT_CODE:
        if (!supply_good_s || !clamp_request_n_s)
          clamp_next = DCT_CLAMPED;
        else if (code_written_reg)
          clamp_next = DCT_DRIVING;
      DCT_DRIVING:
        if (!supply_good_s || !clamp_request_n_s)
          clamp_next = DCT_CLAMPED;
      default:
        clamp_next = DCT_CLAMPED;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      clamp_reg <= DCT_CLAMPED;
    else
      clamp_reg <= clamp_next;
  end

  // Gates: amplifier open and clamp closed unless driving
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      amp_output_gate <= 1'b0;
      ground_clamp_gate <= 1'b1;
    end
    // The request acts on the gates at once, without waiting for the state register
    else if (!clamp_request_n_s || clamp_next != DCT_DRIVING)
    begin
      amp_output_gate <= 1'b0;
      ground_clamp_gate <= 1'b1;
    end
    else
    begin
      amp_output_gate <= 1'b1;
      ground_clamp_gate <= 1'b0;
    end
  end
endmodule

// ==== testbench/dct_trim_bank_sva.sv ====
// Assertion checker for the trim register bank pins
`timescale 1ns/1ps
module dct_trim_bank_chk
  import dct_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Supply and clamp
  input wire logic supply_good,
  input wire logic clamp_request_n,
  input wire logic supply_ok_out,
  input wire logic amp_output_gate,
  input wire logic ground_clamp_gate,
  // Port pins
  input wire logic port_pin_zero_out,
  input wire logic port_pin_zero_oe_n,
  input wire logic port_pin_one_in,
  input wire logic port_pin_one_oe_n,
  input wire logic [1:0] port_value
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  chk_reset_gates: assert property ($fell(reset) |-> ground_clamp_gate && !amp_output_gate)
    else $error("gates not clamped after reset");
  chk_reset_dirs: assert property ($fell(reset) |-> port_pin_zero_oe_n && port_pin_one_oe_n)
    else $error("port pin driving after reset");
  chk_gates_apart: assert property (amp_output_gate != ground_clamp_gate)
    else $error("both gates in same state");
  chk_request_clamp: assert property (!clamp_request_n [*5] |-> ground_clamp_gate && !amp_output_gate)
    else $error("clamp request ignored");
  chk_supply_loss: assert property (!supply_good [*5] |-> ground_clamp_gate && !amp_output_gate)
    else $error("output driven without supply");
  chk_supply_mirror: assert property ($stable(supply_good) [*5] |-> supply_ok_out == supply_good)
    else $error("supply output wrong");
  chk_release_cause: assert property ($rose(amp_output_gate) |-> supply_ok_out && clamp_request_n)
    else $error("release without cause");
  chk_port_drive: assert property (!port_pin_zero_oe_n |-> port_value[0] == port_pin_zero_out)
    else $error("output pin value unreadable");
  chk_port_sense: assert property ((port_pin_one_oe_n && $stable(port_pin_one_in)) [*5]
    |-> port_value[1] == port_pin_one_in)
    else $error("input pin state not reflected");

  cover property ($rose(amp_output_gate));
  cover property ($rose(ground_clamp_gate));
  cover property (!port_pin_zero_oe_n);
endmodule

bind dct_trim_bank dct_trim_bank_chk #(.CHANNELS(CHANNELS)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .supply_good(supply_good), .clamp_request_n(clamp_request_n),
  .supply_ok_out(supply_ok_out), .amp_output_gate(amp_output_gate), .ground_clamp_gate(ground_clamp_gate),
  .port_pin_zero_out(port_pin_zero_out), .port_pin_zero_oe_n(port_pin_zero_oe_n),
  .port_pin_one_in(port_pin_one_in), .port_pin_one_oe_n(port_pin_one_oe_n), .port_value(port_value)
);

// ==== testbench/dct_host_model.sv ====
// Serial host model that shifts command words into the bank
`timescale 1ns/1ps
module dct_host_model
  import dct_pkg::*;
(
  // Pacing clock
  input wire logic clk_sys,
  // Link pins
  output logic link_clk,
  output logic link_frame_n,
  output logic link_din
);
  initial
  begin
    link_clk = 1'b1;
    link_frame_n = 1'b1;
    link_din = 1'b0;
  end

  // Link clock idles high, toggles only in a frame, 4 system cycles per half
  // A count below the word length cuts the frame after that many bits
  task automatic send(input logic [WORD_BITS-1:0] word, input int nbits);
    link_frame_n = 1'b0;
    for (int i = WORD_BITS - 1; i >= WORD_BITS - nbits; i--)
    begin
      link_din = word[i];
      repeat (4) @(negedge clk_sys);
      link_clk = 1'b0;
      repeat (4) @(negedge clk_sys);
      link_clk = 1'b1;
    end
    link_frame_n = 1'b1;
    // Released data line shows no stale bit
    link_din = ~word[WORD_BITS - nbits];
    repeat (4) @(negedge clk_sys);
  endtask
endmodule

// ==== testbench/dct_trim_bank_bench.sv ====
// Self-checking bench for the DAC channel trim register bank
`timescale 1ns/1ps
module dct_trim_bank_bench
  import dct_pkg::*;
();
  logic clk_sys, reset, link_clk, link_frame_n, link_din;
  logic supply_good, clamp_request_n, pin0_in, pin1_in;
  logic [63:0] code;
  logic [7:0] range;
  logic [23:0] gain;
  logic [31:0] offs;
  logic sup_ok, amp, clampg, gadj, p0_out, p0_oe_n, p1_out, p1_oe_n, rb, clr, ld;
  int n_clear;
  int n_load;
  logic [1:0] pval;
  int n_mismatch;
  int check_count;

  dct_host_model host (.clk_sys(clk_sys), .link_clk(link_clk), .link_frame_n(link_frame_n), .link_din(link_din));

  dct_trim_bank #(.CHANNELS(NUM_CH)) DUT (
    .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk), .link_frame_n(link_frame_n), .link_din(link_din),
    .supply_good(supply_good), .clamp_request_n(clamp_request_n), .supply_ok_out(sup_ok),
    .amp_output_gate(amp), .ground_clamp_gate(clampg), .channel_output_code(code),
    .channel_range_select(range), .channel_gain_trim(gain), .channel_offset_trim(offs),
    .ground_adjust_en(gadj), .readback_disable(rb), .output_clear(clr), .output_load(ld),
    .port_pin_zero_in(pin0_in), .port_pin_zero_out(p0_out), .port_pin_zero_oe_n(p0_oe_n),
    .port_pin_one_in(pin1_in), .port_pin_one_out(p1_out), .port_pin_one_oe_n(p1_oe_n), .port_value(pval)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // One-cycle strobes counted at the falling edge, where they stand settled
  always @(negedge clk_sys)
  begin
    if (clr === 1'b1)
      n_clear++;
    if (ld === 1'b1)
      n_load++;
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] sel, input logic [2:0] addr, input logic [15:0] data);
    host.send({sel, addr, 2'b00, data}, WORD_BITS);
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    $display("timeout");
    finish_test();
  end

  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    reset = 1'b1;
    supply_good = 1'b0;
    clamp_request_n = 1'b1;
    pin0_in = 1'b0;
    pin1_in = 1'b0;
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    check("code", code, 64'h0);
    check("trims", {range, gain, offs}, 64'h0);
    check("gates", {amp, clampg}, 2'b01);
    check("dirs", {p0_oe_n, p1_oe_n}, 2'b11);
    wr(SEL_OUTPUT_CODE, 3'h1, 16'h8001);
    check("code", code, 64'h0000_0000_8001_0000);
    check("gates", {amp, clampg}, 2'b01);
    supply_good = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("supply", sup_ok, 1'b1);
    check("gates", {amp, clampg}, 2'b01);
    wr(SEL_OUTPUT_CODE, 3'h3, 16'hc35a);
    check("code", code, 64'hc35a_0000_8001_0000);
    check("gates", {amp, clampg}, 2'b10);
    for (int i = 0; i < 3; i++)
      wr(SEL_RANGE, 3'(i), 16'hfffc | 16'(i));
    check("range", range, 8'h24);
    wr(SEL_GAIN_TRIM, 3'h1, 16'hffe0);
    check("gain", gain, 24'h000800);
    wr(SEL_GAIN_TRIM, ADDR_ALL, 16'hff1f);
    check("gain", gain, {4{6'h1f}});
    wr(SEL_OFFSET_TRIM, 3'h0, 16'hfff0);
    check("offset", offs, 32'h000000f0);
    wr(3'h1, 3'h0, 16'hffff);
    wr(SEL_OFFSET_TRIM, 3'h5, 16'h0011);
    check("offset", offs, 32'h000000f0);
    host.send({SEL_OFFSET_TRIM, 3'h1, 2'b00, 16'h0033}, WORD_BITS / 2);
    wr(SEL_OFFSET_TRIM, 3'h2, 16'h0044);
    check("offset", offs, 32'h004400f0);
    check("code", code, 64'hc35a_0000_8001_0000);
    pin1_in = 1'b1;
    wr(SEL_FUNCTION, FUNC_CONFIG, 16'h002e);
    check("ground adjust", gadj, 1'b1);
    check("pin drive", {p0_oe_n, p0_out, p1_oe_n, p1_out}, 4'b0110);
    check("port", pval, 2'b11);
    pin1_in = 1'b0;
    repeat (6) @(negedge clk_sys);
    check("port", pval, 2'b01);
    wr(SEL_FUNCTION, FUNC_CONFIG, 16'h0001);
    check("ground adjust", gadj, 1'b0);
    check("dirs", {p0_oe_n, p1_oe_n}, 2'b11);
    check("readback off", rb, 1'b1);
    check("port", pval, 2'b00);
    pin0_in = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("port", pval, 2'b01);
    wr(SEL_FUNCTION, FUNC_NOP, 16'hffff);
    check("nop", {rb, gadj, p0_oe_n, p1_oe_n}, 4'b1011);
    wr(SEL_FUNCTION, FUNC_CLEAR, 16'h0000);
    check("clear strobes", n_clear, 8'h01);
    check("load strobes", n_load, 8'h00);
    wr(SEL_FUNCTION, FUNC_LOAD, 16'h0000);
    check("load strobes", n_load, 8'h01);
    clamp_request_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("gates", {amp, clampg}, 2'b01);
    clamp_request_n = 1'b1;
    supply_good = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("supply", sup_ok, 1'b0);
    check("gates", {amp, clampg}, 2'b01);
    supply_good = 1'b1;
    repeat (8) @(negedge clk_sys);
    wr(SEL_OUTPUT_CODE, 3'h6, 16'h0001);
    check("gates", {amp, clampg}, 2'b01);
    check("code", code, 64'hc35a_0000_8001_0000);
    wr(SEL_OUTPUT_CODE, 3'h0, 16'h0001);
    check("gates", {amp, clampg}, 2'b10);
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    check("trims", {range, gain, offs}, 64'h0);
    check("gates", {amp, clampg}, 2'b01);
    check("readback off", rb, 1'b0);
    finish_test();
  end
endmodule
